// ---- hdl/ecr_pkg.sv ----
// Package for the exception cause recorder: register map, field layout,
// exception codes and the carrier struct shared by the design and bench.
// Assumes a 32-bit classic Wishbone register bus, word addressed by byte.
package ecr_pkg;

    // Register byte offsets
    localparam logic [7:0] ECR_OFF_CAUSE   = 8'h00;
    localparam logic [7:0] ECR_OFF_CTRL    = 8'h04;
    localparam logic [7:0] ECR_OFF_COUNT   = 8'h08;
    localparam logic [7:0] ECR_OFF_COMPARE = 8'h0C;
    localparam logic [7:0] ECR_OFF_RET_PC  = 8'h10;

    // Cause register field positions
    localparam int ECR_B_DELAY    = 31;
    localparam int ECR_B_TIMER    = 30;
    localparam int ECR_B_CE_LO    = 28;
    localparam int ECR_B_CNT_DIS  = 27;
    localparam int ECR_B_PERF     = 26;
    localparam int ECR_B_VEC_SEL  = 23;
    localparam int ECR_B_WATCH    = 22;
    localparam int ECR_B_PEND_LO  = 8;
    localparam int ECR_B_CODE_LO  = 2;

    // Control register field positions
    localparam int ECR_B_MASK_LO  = 0;
    localparam int ECR_B_EXT_MODE = 8;

    // Reset values
    localparam logic [31:0] ECR_RST_WORD   = 32'h0000_0000;
    localparam logic [31:0] ECR_RST_COMPARE = 32'hFFFF_FFFF;

    // Offset from a branch to its delay slot instruction
    localparam logic [31:0] ECR_INSN_BYTES = 32'h0000_0004;

    // Recorded exception codes
    typedef enum logic [4:0] {
        ECR_CODE_INTERRUPT     = 5'h00,
        ECR_CODE_PAGE_RDONLY   = 5'h01,
        ECR_CODE_LOAD_PAGE_INV = 5'h02,
        ECR_CODE_STORE_PAGE_INV= 5'h03,
        ECR_CODE_LOAD_ADDR_ERR = 5'h04,
        ECR_CODE_STORE_ADDR_ERR= 5'h05,
        ECR_CODE_FETCH_BUS_ERR = 5'h06,
        ECR_CODE_DATA_BUS_ERR  = 5'h07,
        ECR_CODE_SYSCALL       = 5'h08,
        ECR_CODE_BREAKPOINT    = 5'h09,
        ECR_CODE_ILLEGAL_INSN  = 5'h0A,
        ECR_CODE_COPROC_UNUSE  = 5'h0B,
        ECR_CODE_ARITH_OVFL    = 5'h0C
    } ecr_code_e;

    // Exception entry reported by the pipeline
    typedef struct packed {
        logic        valid;
        ecr_code_e   code;
        logic        in_delay;
        logic [31:0] pc;
        logic [1:0]  coproc;
    } ecr_exc_s;

endpackage

// ---- hdl/ecr_cause_recorder.sv ----
// Exception cause recorder: cause snapshot, pending interrupts, cycle timer
// and return address, reached over a classic Wishbone slave.
// Assumes the pipeline pulses exc.valid for one cycle per exception taken and
// that every input is synchronous to clock.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps

// Functional notes
// RULE_01: Delay slot exception sets in_delay_slot and return pc points at branch.
// RULE_02: timer_irq_flag set when the last interrupt came from the timer.
// RULE_03: Coprocessor unusable exception records the coprocessor number used.
// RULE_04: count_disable is writable and freezes the cycle counter while one.
// RULE_05: perf_overflow_irq set when the last interrupt was a counter overflow.
// RULE_06: interrupt_vector_select is writable and picks the dedicated interrupt entry.
// RULE_07: Watch match during exception mode sets watch_pending; software writes zero only.
// RULE_08: watch_pending re-raises the watch exception once exceptions are allowed.
// RULE_09: irq_pending mirrors request inputs; interrupt possible when pending and masked in.
// RULE_10: Two low pending bits are software written interrupt requests.
// RULE_11: External mode shows requested_priority_level captured at the exception.
// RULE_12: Only the writable cause fields change on writes; others ignore them.
// RULE_13: Codes 0 interrupt, 1 read-only page store, 2 and 3 invalid page.
// RULE_14: Codes 4 and 5 are address errors on load or fetch and store.
// RULE_15: Codes 6 fetch bus error and 7 imprecise data bus error.
// RULE_16: Codes 8 system call, 9 breakpoint, 10 illegal instruction.
// RULE_17: Codes 11 coprocessor unusable and 12 trapping arithmetic overflow.
// RULE_18: Every exception overwrites exception_code with its cause.
// RULE_19: irq_mask enables each pending bit, or is a threshold in external mode.
// RULE_20: Timer interrupt rises on count equal compare, cleared by compare write.
// RULE_21: Delay flag, code and source flags update together on exception entry.
// RULE_22: Recorded exception fields hold until the next exception is taken.
module ecr_cause_recorder
    import ecr_pkg::*;
(
    // Clock and reset
    input  logic        clock,
    input  logic        rst_n,
    // Wishbone slave
    input  logic        wb_cyc_i,
    input  logic        wb_stb_i,
    input  logic        wb_we_i,
    input  logic [7:0]  wb_adr_i,
    input  logic [3:0]  wb_sel_i,
    input  logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic        wb_ack_o,
    // Pipeline side
    input  ecr_exc_s    exc,
    input  logic        core_in_exc_mode,
    input  logic        watch_match,
    input  logic        perf_overflow,
    input  logic [5:0]  irq_lines,
    // Results toward the pipeline
    output logic        irq_request,
    output logic        watch_retrigger,
    output logic        vector_select,
    output logic        timer_irq,
    output logic [31:0] exception_return_pc
);

    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic        in_delay_slot;
        logic        timer_irq_flag;
        logic [1:0]  unusable_coproc_num;
        logic        count_disable;
        logic        perf_overflow_irq;
        logic        interrupt_vector_select;
        logic        watch_pending;
        logic [1:0]  sw_pending;
        logic [5:0]  requested_priority_level;
        ecr_code_e   exception_code;
        logic [31:0] ret_pc;
        logic [7:0]  irq_mask;
        logic        external_controller_mode;
        logic [31:0] count;
        logic [31:0] compare;
        logic        timer_irq;
        logic        irq_req;
        logic        watch_retry;
    } ecr_state_s;

    ecr_state_s st_q;
    ecr_state_s st_d;

    logic        bus_req;
    logic        wr_go;
    logic [31:0] cause_word;
    logic [31:0] ctrl_word;
    logic [7:0]  pending;

    // Byte-lane merge for writable words
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i;
    // Writes commit on the edge where the master sees ack high
    assign wr_go   = bus_req && wb_ack_o && wb_we_i;

    // Live pending view; software bits sit in the two lowest positions
    assign pending = {irq_lines, st_q.sw_pending}; // [RULE_09] [RULE_10]

    always_comb begin
        cause_word = ECR_RST_WORD;
        cause_word[ECR_B_DELAY]   = st_q.in_delay_slot;
        cause_word[ECR_B_TIMER]   = st_q.timer_irq_flag;
        cause_word[ECR_B_CE_LO +: 2] = st_q.unusable_coproc_num;
        cause_word[ECR_B_CNT_DIS] = st_q.count_disable;
        cause_word[ECR_B_PERF]    = st_q.perf_overflow_irq;
        cause_word[ECR_B_VEC_SEL] = st_q.interrupt_vector_select;
        cause_word[ECR_B_WATCH]   = st_q.watch_pending;
        if (st_q.external_controller_mode) begin
            cause_word[ECR_B_PEND_LO+2 +: 6] = st_q.requested_priority_level; // [RULE_11]
            cause_word[ECR_B_PEND_LO +: 2]   = st_q.sw_pending;
        end else begin
            cause_word[ECR_B_PEND_LO +: 8] = pending; // [RULE_09]
        end
        cause_word[ECR_B_CODE_LO +: 5] = st_q.exception_code;
        ctrl_word = ECR_RST_WORD;
        ctrl_word[ECR_B_MASK_LO +: 8] = st_q.irq_mask;
        ctrl_word[ECR_B_EXT_MODE]     = st_q.external_controller_mode;
    end

    always_comb begin
        logic [31:0] wv;
        logic        cmp_write;
        wv        = ECR_RST_WORD;
        cmp_write = 1'b0;
        st_d      = st_q;

        // Wishbone: answer one cycle after the request, drop ack the cycle after
        st_d.ack  = bus_req && !st_q.ack;
        st_d.rdat = ECR_RST_WORD;
        if (bus_req && !st_q.ack && !wb_we_i) begin
            if (wb_adr_i == ECR_OFF_CAUSE) begin
                st_d.rdat = cause_word;
            end else if (wb_adr_i == ECR_OFF_CTRL) begin
                st_d.rdat = ctrl_word;
            end else if (wb_adr_i == ECR_OFF_COUNT) begin
                st_d.rdat = st_q.count;
            end else if (wb_adr_i == ECR_OFF_COMPARE) begin
                st_d.rdat = st_q.compare;
            end else if (wb_adr_i == ECR_OFF_RET_PC) begin
                st_d.rdat = st_q.ret_pc;
            end else begin
                st_d.rdat = ECR_RST_WORD;
            end
        end

        // Free-running counter, frozen by count_disable
        if (!st_q.count_disable) begin
            st_d.count = st_q.count + 32'h0000_0001; // [RULE_04]
        end

        // Register writes; only the writable cause fields are taken
        if (wr_go) begin
            if (wb_adr_i == ECR_OFF_CAUSE) begin
                wv = merge_lanes(cause_word, wb_dat_i, wb_sel_i);
                st_d.count_disable           = wv[ECR_B_CNT_DIS]; // [RULE_04] [RULE_12]
                st_d.interrupt_vector_select = wv[ECR_B_VEC_SEL]; // [RULE_06]
                if (!wv[ECR_B_WATCH]) begin
                    st_d.watch_pending = 1'b0; // [RULE_07]
                end
                st_d.sw_pending = wv[ECR_B_PEND_LO +: 2]; // [RULE_10]
            end else if (wb_adr_i == ECR_OFF_CTRL) begin
                wv = merge_lanes(ctrl_word, wb_dat_i, wb_sel_i);
                st_d.irq_mask                 = wv[ECR_B_MASK_LO +: 8];
                st_d.external_controller_mode = wv[ECR_B_EXT_MODE];
            end else if (wb_adr_i == ECR_OFF_COUNT) begin
                st_d.count = merge_lanes(st_q.count, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == ECR_OFF_COMPARE) begin
                st_d.compare = merge_lanes(st_q.compare, wb_dat_i, wb_sel_i);
                cmp_write    = 1'b1;
            end
        end

        // Timer: compare write clears, a match in the same cycle still sets
        if (cmp_write) begin
            st_d.timer_irq = 1'b0; // [RULE_20]
        end
        if (st_q.count == st_q.compare) begin
            st_d.timer_irq = 1'b1; // [RULE_20]
        end

        // Watch hit that cannot be taken now is remembered; set beats clear
        if (watch_match && core_in_exc_mode) begin
            st_d.watch_pending = 1'b1; // [RULE_07]
        end
        st_d.watch_retry = st_q.watch_pending && !core_in_exc_mode; // [RULE_08]

        // Interrupt gating: bitwise enables, or a priority threshold
        if (st_q.external_controller_mode) begin
            st_d.irq_req = irq_lines > st_q.irq_mask[7:2]; // [RULE_19]
        end else begin
            st_d.irq_req = |(pending & st_q.irq_mask); // [RULE_09] [RULE_19]
        end

        // One consistent snapshot per exception; held until the next one
        if (exc.valid) begin // [RULE_18] [RULE_21] [RULE_22]
            st_d.exception_code = exc.code; // [RULE_13] [RULE_14] [RULE_15] [RULE_16] [RULE_17]
            st_d.in_delay_slot  = exc.in_delay; // [RULE_01]
            st_d.ret_pc = exc.in_delay ? exc.pc - ECR_INSN_BYTES : exc.pc; // [RULE_01]
            if (exc.code == ECR_CODE_COPROC_UNUSE) begin
                st_d.unusable_coproc_num = exc.coproc; // [RULE_03]
            end else begin
                st_d.unusable_coproc_num = 2'h0;
            end
            if (exc.code == ECR_CODE_INTERRUPT) begin
                st_d.timer_irq_flag    = st_q.timer_irq; // [RULE_02]
                st_d.perf_overflow_irq = perf_overflow; // [RULE_05]
                st_d.requested_priority_level = irq_lines; // [RULE_11]
            end else begin
                st_d.timer_irq_flag    = 1'b0;
                st_d.perf_overflow_irq = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{ack: 1'b0, rdat: ECR_RST_WORD, in_delay_slot: 1'b0,
                      timer_irq_flag: 1'b0, unusable_coproc_num: 2'h0,
                      count_disable: 1'b0, perf_overflow_irq: 1'b0,
                      interrupt_vector_select: 1'b0, watch_pending: 1'b0,
                      sw_pending: 2'h0, requested_priority_level: 6'h00,
                      exception_code: ECR_CODE_INTERRUPT, ret_pc: ECR_RST_WORD,
                      irq_mask: 8'h00, external_controller_mode: 1'b0,
                      count: ECR_RST_WORD, compare: ECR_RST_COMPARE,
                      timer_irq: 1'b0, irq_req: 1'b0, watch_retry: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign wb_ack_o            = st_q.ack;
    assign wb_dat_o            = st_q.rdat;
    assign irq_request         = st_q.irq_req;
    assign watch_retrigger     = st_q.watch_retry;
    assign vector_select       = st_q.interrupt_vector_select; // [RULE_06]
    assign timer_irq           = st_q.timer_irq;
    assign exception_return_pc = st_q.ret_pc;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_exc_entry;
        exc.valid;
    endsequence

    sequence s_int_entry;
        exc.valid && exc.code == ECR_CODE_INTERRUPT;
    endsequence

    property p_delay_slot;
        s_exc_entry ##0 exc.in_delay |=>
            st_q.in_delay_slot && exception_return_pc == $past(exc.pc) - ECR_INSN_BYTES;
    endproperty
    a_delay_slot: assert property (p_delay_slot) // [RULE_01]
        else $error("Return pc not at branch");

    property p_timer_flag;
        s_int_entry |=> st_q.timer_irq_flag == $past(st_q.timer_irq);
    endproperty
    a_timer_flag: assert property (p_timer_flag) // [RULE_02]
        else $error("Timer source flag wrong");

    property p_coproc;
        s_exc_entry ##0 exc.code == ECR_CODE_COPROC_UNUSE |=>
            st_q.unusable_coproc_num == $past(exc.coproc);
    endproperty
    a_coproc: assert property (p_coproc) // [RULE_03]
        else $error("Coprocessor number not recorded");

    property p_count_frozen;
        st_q.count_disable && !wr_go |=> st_q.count == $past(st_q.count);
    endproperty
    a_count_frozen: assert property (p_count_frozen) // [RULE_04]
        else $error("Counter moved while disabled");

    property p_count_runs;
        // Sampled reset keeps out the release edge, where the counter is still held
        rst_n && !st_q.count_disable && !wr_go |=>
            st_q.count == $past(st_q.count) + 32'h0000_0001;
    endproperty
    a_count_runs: assert property (p_count_runs) // [RULE_04]
        else $error("Counter did not advance");

    property p_perf_flag;
        s_int_entry |=> st_q.perf_overflow_irq == $past(perf_overflow);
    endproperty
    a_perf_flag: assert property (p_perf_flag) // [RULE_05]
        else $error("Overflow source flag wrong");

    property p_watch_set;
        watch_match && core_in_exc_mode |=> st_q.watch_pending;
    endproperty
    a_watch_set: assert property (p_watch_set) // [RULE_07]
        else $error("Watch hit not remembered");

    property p_watch_retry;
        st_q.watch_pending && !core_in_exc_mode |=> watch_retrigger;
    endproperty
    a_watch_retry: assert property (p_watch_retry) // [RULE_08]
        else $error("Watch exception not repeated");

    property p_irq_gate;
        !st_q.external_controller_mode && !wr_go |=>
            irq_request == |($past(pending) & $past(st_q.irq_mask));
    endproperty
    a_irq_gate: assert property (p_irq_gate) // [RULE_09]
        else $error("Interrupt request gating wrong");

    property p_code_load;
        s_exc_entry |=> st_q.exception_code == $past(exc.code);
    endproperty
    a_code_load: assert property (p_code_load) // [RULE_18]
        else $error("Exception code not recorded");

    property p_code_hold;
        !exc.valid |=> $stable(st_q.exception_code) && $stable(st_q.in_delay_slot);
    endproperty
    a_code_hold: assert property (p_code_hold) // [RULE_22]
        else $error("Snapshot changed without exception");

    property p_timer_clear;
        wr_go && wb_adr_i == ECR_OFF_COMPARE && st_q.count != st_q.compare |=> !timer_irq;
    endproperty
    a_timer_clear: assert property (p_timer_clear) // [RULE_20]
        else $error("Compare write did not clear");

    property p_ack_pulse;
        bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Bus answer not a one-cycle pulse");

    property p_vec_write;
        wr_go && wb_adr_i == ECR_OFF_CAUSE && wb_sel_i[2] |=>
            vector_select == $past(wb_dat_i[ECR_B_VEC_SEL]);
    endproperty
    a_vec_write: assert property (p_vec_write) // [RULE_06]
        else $error("Vector select write not taken");

    property p_sw_write;
        wr_go && wb_adr_i == ECR_OFF_CAUSE && wb_sel_i[1] |=>
            st_q.sw_pending == $past(wb_dat_i[ECR_B_PEND_LO +: 2]);
    endproperty
    a_sw_write: assert property (p_sw_write) // [RULE_10]
        else $error("Software request bits not taken");

    property p_prio_capture;
        s_int_entry |=>
            st_q.requested_priority_level == $past(irq_lines);
    endproperty
    a_prio_capture: assert property (p_prio_capture) // [RULE_11]
        else $error("Priority level not captured");

    property p_timer_set;
        st_q.count == st_q.compare |=>
            timer_irq;
    endproperty
    a_timer_set: assert property (p_timer_set) // [RULE_20]
        else $error("Timer match did not raise");

    property p_ext_gate;
        st_q.external_controller_mode |=>
            irq_request == ($past(irq_lines) > $past(st_q.irq_mask[7:2]));
    endproperty
    a_ext_gate: assert property (p_ext_gate) // [RULE_19]
        else $error("Priority threshold gating wrong");

    property p_flags_clear;
        s_exc_entry ##0 exc.code != ECR_CODE_INTERRUPT |=>
            !st_q.timer_irq_flag && !st_q.perf_overflow_irq;
    endproperty
    a_flags_clear: assert property (p_flags_clear) // [RULE_21]
        else $error("Source flags kept on non-interrupt");

endmodule

// ---- testbench/ecr_pipe_model.sv ----
// Pipeline and interrupt source model that feeds the cause recorder.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/1ps
module ecr_pipe_model
    import ecr_pkg::*;
(
    // Clock
    input  wire logic  clock,
    // Toward the recorder
    output ecr_exc_s   exc,
    output logic       core_in_exc_mode,
    output logic       watch_match,
    output logic       perf_overflow,
    output logic [5:0] irq_lines
);
    initial begin
        exc              = '0;
        core_in_exc_mode = 1'b0;
        watch_match      = 1'b0;
        perf_overflow    = 1'b0;
        irq_lines        = 6'h00;
    end

    // One-cycle entry pulse; in_delay, pc and coproc invert afterwards so their stale values never match, while code is kept
    task automatic take(input ecr_code_e c, input logic d, input logic [31:0] p,
                        input logic [1:0] cp);
        @(posedge clock);
        exc <= '{1'b1, c, d, p, cp};
        @(posedge clock);
        exc <= '{1'b0, c, ~d, ~p, ~cp};
    endtask

    task automatic set_irq(input logic [5:0] l, input logic pf);
        @(posedge clock);
        irq_lines     <= l;
        perf_overflow <= pf;
    endtask

    task automatic set_mode(input logic m);
        @(posedge clock);
        core_in_exc_mode <= m;
    endtask

    // One-cycle watch_match pulse; the bench clears the pending watch over the bus
    task automatic watch_hit();
        @(posedge clock);
        watch_match <= 1'b1;
        @(posedge clock);
        watch_match <= 1'b0;
    endtask
endmodule

// ---- testbench/ecr_cause_recorder_tb_top.sv ----
// Self-checking bench for the cause recorder, Wishbone register tasks and a
// pipeline model. Assumes the register map and field layout of ecr_pkg.
`timescale 1ns/1ps
module ecr_cause_recorder_tb_top;
    import ecr_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [3:0]  sel   = 4'h0;
    logic [31:0] wdat  = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    ecr_exc_s    exc;
    logic        exc_mode, watch, perf, irq_req, retrig, vsel, tirq;
    logic [5:0]  lines;
    logic [31:0] ret_pc, q, q2;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #5 clock = ~clock;

    ecr_pipe_model i_pipe (.clock(clock), .exc(exc), .core_in_exc_mode(exc_mode),
        .watch_match(watch), .perf_overflow(perf), .irq_lines(lines));

    ecr_cause_recorder i_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .exc(exc), .core_in_exc_mode(exc_mode), .watch_match(watch),
        .perf_overflow(perf), .irq_lines(lines), .irq_request(irq_req),
        .watch_retrigger(retrig), .vector_select(vsel), .timer_irq(tirq),
        .exception_return_pc(ret_pc));

    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask

    // Single classic cycle; a missing ack counts as a mismatch
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clock);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        if (n >= 50) begin
            chk("ack", 32'h1, 32'h0);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rdm(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0000_0000, r);
        chk(what, e, r & m);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    initial begin
        tick(4);
        rst_n <= 1'b1;
        rdm("cause", ECR_OFF_CAUSE, 32'hFFFF_FFFF, ECR_RST_WORD);
        rdm("compare", ECR_OFF_COMPARE, 32'hFFFF_FFFF, ECR_RST_COMPARE);
        rdm("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(ECR_OFF_CTRL, 32'h0000_0000);
        for (int k = 1; k <= 12; k++) begin
            i_pipe.take(ecr_code_e'(k), 1'b0, 32'h0000_1000 + k * 16, 2'b10);
            tick(1);
            chk("return pc", 32'h0000_1000 + k * 16, ret_pc);
            wb(1'b0, ECR_OFF_CAUSE, 32'h0000_0000, q);
            chk("code", k << 2, q & 32'h0000_007C);
            chk("rest", k == 11 ? 32'h2000_0000 : 32'h0, q & 32'hFFFF_FF83);
        end
        // Delay slot entry restarts at the branch one instruction earlier
        i_pipe.take(ECR_CODE_BREAKPOINT, 1'b1, 32'h0000_0200, 2'b00);
        tick(1);
        chk("return pc", 32'h0000_01FC, ret_pc);
        rdm("cause", ECR_OFF_CAUSE, 32'hFFFF_FFFF, 32'h8000_0024);
        i_pipe.take(ECR_CODE_ARITH_OVFL, 1'b0, 32'h0000_0300, 2'b11);
        wr(ECR_OFF_CAUSE, 32'hFFFF_FFFF);
        rdm("rw", ECR_OFF_CAUSE, 32'hFFFF_FFFF, 32'h0880_0330);
        chk("vector select", 32'h1, {31'h0, vsel});
        wb(1'b0, ECR_OFF_COUNT, 32'h0, q);
        wb(1'b0, ECR_OFF_COUNT, 32'h0, q2);
        chk("frozen count", q, q2);
        // Watch hit while already in exception mode is held, then retried
        i_pipe.set_mode(1'b1);
        i_pipe.watch_hit();
        tick(2);
        chk("retrigger", 32'h0, {31'h0, retrig});
        rdm("watch", ECR_OFF_CAUSE, 32'h0040_0000, 32'h0040_0000);
        i_pipe.set_mode(1'b0);
        tick(2);
        chk("retrigger", 32'h1, {31'h0, retrig});
        wr(ECR_OFF_CAUSE, 32'h0000_0000);
        tick(2);
        chk("retrigger", 32'h0, {31'h0, retrig});
        chk("vector select", 32'h0, {31'h0, vsel});
        // Live pending bits against the per-bit mask
        i_pipe.set_irq(6'h15, 1'b0);
        rdm("pending", ECR_OFF_CAUSE, 32'h0000_FC00, 32'h0000_5400);
        wr(ECR_OFF_CTRL, 32'h0000_0004);
        tick(2);
        chk("irq request", 32'h1, {31'h0, irq_req});
        wr(ECR_OFF_CTRL, 32'h0000_0008);
        tick(2);
        chk("irq request", 32'h0, {31'h0, irq_req});
        // External mode: threshold 16, level captured at entry
        wr(ECR_OFF_CTRL, 32'h0000_0140);
        i_pipe.set_irq(6'h2A, 1'b0);
        tick(2);
        chk("irq request", 32'h1, {31'h0, irq_req});
        i_pipe.take(ECR_CODE_INTERRUPT, 1'b0, 32'h0000_0400, 2'b00);
        i_pipe.set_irq(6'h05, 1'b0);
        tick(2);
        chk("irq request", 32'h0, {31'h0, irq_req});
        rdm("priority", ECR_OFF_CAUSE, 32'h0000_FC00, 32'h0000_A800);
        // Timer match, flags at interrupt entry, clear on compare write
        wr(ECR_OFF_CTRL, 32'h0000_0000);
        wr(ECR_OFF_COUNT, 32'h0000_0000);
        wr(ECR_OFF_COMPARE, 32'h0000_0040);
        for (int n = 0; n < 200 && tirq !== 1'b1; n++) tick(1);
        chk("timer irq", 32'h1, {31'h0, tirq});
        i_pipe.set_irq(6'h00, 1'b1);
        i_pipe.take(ECR_CODE_INTERRUPT, 1'b0, 32'h0000_0500, 2'b00);
        i_pipe.set_irq(6'h00, 1'b0);
        rdm("src", ECR_OFF_CAUSE, 32'h7400_007C, 32'h4400_0000);
        wr(ECR_OFF_COMPARE, 32'hFFFF_FFFF);
        tick(2);
        chk("timer irq", 32'h0, {31'h0, tirq});
        results();
    end
endmodule
